// [lteq_config.sv]
// Notes on behaviour
// - Register 0 low five bits hold the equalizer select, read/write, reset zero.
// - Host mode: register 1 bit 7 set gives internal receive termination.
// - Host mode: register 1 bit 6 set gives internal transmit termination.
// - Register 1 bits 5:4 pick impedance: 01 110, 10 75, 11 120 ohms.
// - Impedance code applies only in host mode with both terminations internal.
// - Internal receive termination uses internal resistors, optionally plus one fixed resistor.
// - Register 0 bits 7:5 are spare read/write bits, reset zero, no effect.
// - Serial host port reaches five byte registers by five-bit number among thirty-two addresses.
`timescale 1ns/1ps
`default_nettype none
module lteq_config #(
	parameter logic [7:0] DEV_ID = lteq_pkg::LTEQ_DEV_ID_DEF,
	parameter logic [7:0] REV_ID = lteq_pkg::LTEQ_REV_ID_DEF
) (
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       host_mode_i,
	input  wire logic       sp_cs_n_i,
	input  wire logic       sp_sclk_i,
	input  wire logic       sp_sdi_i,
	output var  logic       sp_sdo_o,
	output var  logic       sp_sdo_oe_o,
	output var  logic [4:0] eq_select_o,
	output var  logic       rx_internal_term_o,
	output var  logic       tx_internal_term_o,
	output var  logic       term_impedance_apply_o,
	output var  logic [1:0] term_impedance_code_o,
	output var  logic [7:0] term_impedance_ohms_o,
	output var  logic       rx_fixed_resistor_o,
	output var  logic [1:0] rx_fixed_resistor_select_o
);
	import lteq_pkg::*;

	logic [3:0]  sync1_q;
	logic [3:0]  sync2_q;
	logic        sclk_prev_q;
	logic        cs_n_s;
	logic        sclk_s;
	logic        sdi_s;
	logic        host_s;
	logic        sclk_rise;
	logic        sclk_fall;
	lteq_state_t state_q;
	logic [3:0]  cnt_q;
	logic [7:0]  shift_q;
	logic [7:0]  shift_next;
	logic        rw_q;
	logic [4:0]  addr_q;
	logic [7:0]  rdata_q;
	logic [7:0]  hdr_rdata;
	logic        commit;
	logic [7:0]  eq_ctrl_q;
	logic [7:0]  term_ctrl_q;
	logic [7:0]  rx_fixed_resistor_select_q;

	function automatic logic [7:0] read_reg(input logic [4:0] a, input logic [7:0] r0,
		input logic [7:0] r1, input logic [7:0] r3);
		logic [7:0] v;
		v = 8'h00;
		if (a == LTEQ_OFS_EQ_CTRL) v = r0;
		else if (a == LTEQ_OFS_TERM_CTRL) v = r1;
		else if (a == LTEQ_OFS_RX_FIXED_RESISTOR_SELECT) v = r3;
		else if (a == LTEQ_OFS_DEV_ID) v = DEV_ID;
		else if (a == LTEQ_OFS_REV_ID) v = REV_ID;
		return v;
	endfunction

	function automatic logic [7:0] ohms_of(input logic [1:0] code);
		logic [7:0] v;
		v = LTEQ_OHMS_100;
		unique case (code)
			LTEQ_IMP_100: v = LTEQ_OHMS_100;
			LTEQ_IMP_110: v = LTEQ_OHMS_110;
			LTEQ_IMP_75:  v = LTEQ_OHMS_75;
			LTEQ_IMP_120: v = LTEQ_OHMS_120;
		endcase
		return v;
	endfunction

	// Pins are asynchronous to clk_i; only the second stage is read
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1_q <= 4'h1;
			sync2_q <= 4'h1;
			sclk_prev_q <= 1'b0;
		end else begin
			sync1_q <= {host_mode_i, sp_sdi_i, sp_sclk_i, sp_cs_n_i};
			sync2_q <= sync1_q;
			sclk_prev_q <= sync2_q[1];
		end
	end

	assign cs_n_s = sync2_q[0];
	assign sclk_s = sync2_q[1];
	assign sdi_s = sync2_q[2];
	assign host_s = sync2_q[3];
	assign sclk_rise = sclk_s && !sclk_prev_q;
	assign sclk_fall = !sclk_s && sclk_prev_q;
	assign shift_next = {sdi_s, shift_q[7:1]};
	assign hdr_rdata = read_reg(shift_next[5:1], eq_ctrl_q, term_ctrl_q, rx_fixed_resistor_select_q);
	assign commit = (state_q == LTEQ_DATA) && sclk_rise && !cs_n_s && (cnt_q == LTEQ_DATA_LAST) && !rw_q;

	// Serial frame engine; serial clock must be well below clk_i/4
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= LTEQ_IDLE;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			rw_q <= 1'b0;
			addr_q <= 5'h00;
		end else if (cs_n_s) begin
			state_q <= LTEQ_IDLE;
			cnt_q <= 4'h0;
		end else begin
			unique case (state_q)
				LTEQ_IDLE: begin
					state_q <= LTEQ_HDR;
					cnt_q <= 4'h0;
				end
				LTEQ_HDR: begin
					if (sclk_rise) begin
						shift_q <= shift_next;
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == LTEQ_HDR_LAST) begin
							rw_q <= shift_next[0];
							addr_q <= shift_next[5:1];
							state_q <= LTEQ_DATA;
						end
					end
				end
				LTEQ_DATA: begin
					if (sclk_rise) begin
						shift_q <= shift_next;
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == LTEQ_DATA_LAST) begin
							state_q <= LTEQ_DONE;
						end
					end
				end
				LTEQ_DONE: begin
					state_q <= LTEQ_DONE;
				end
			endcase
		end
	end

	// Read data shifts out LSB first, next bit on each falling edge
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_q <= 8'h00;
			sp_sdo_o <= 1'b0;
		end else if (state_q == LTEQ_HDR && sclk_rise && cnt_q == LTEQ_HDR_LAST) begin
			rdata_q <= hdr_rdata;
			sp_sdo_o <= hdr_rdata[0];
		end else if (state_q == LTEQ_DATA && sclk_fall && cnt_q > 4'h8) begin
			sp_sdo_o <= rdata_q[cnt_q[2:0]];
		end
	end

	assign sp_sdo_oe_o = (state_q == LTEQ_DATA) && rw_q && !cs_n_s;

	// Unlisted addresses accept writes and discard them
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			eq_ctrl_q <= LTEQ_RST_EQ_CTRL;
			term_ctrl_q <= LTEQ_RST_TERM_CTRL;
			rx_fixed_resistor_select_q <= LTEQ_RST_RX_FIXED_RESISTOR_SELECT;
		end else if (commit) begin
			if (addr_q == LTEQ_OFS_EQ_CTRL) eq_ctrl_q <= shift_next;
			if (addr_q == LTEQ_OFS_TERM_CTRL) term_ctrl_q <= shift_next;
			if (addr_q == LTEQ_OFS_RX_FIXED_RESISTOR_SELECT) rx_fixed_resistor_select_q <= shift_next;
		end
	end

	assign eq_select_o = eq_ctrl_q[LTEQ_EQ_LSB +: LTEQ_EQ_W];

	// Outside host mode the front end falls back to external termination
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_internal_term_o <= 1'b0;
			tx_internal_term_o <= 1'b0;
			term_impedance_apply_o <= 1'b0;
			term_impedance_code_o <= LTEQ_IMP_100;
			term_impedance_ohms_o <= LTEQ_OHMS_100;
			rx_fixed_resistor_o <= 1'b0;
			rx_fixed_resistor_select_o <= 2'h0;
		end else begin
			rx_internal_term_o <= host_s && term_ctrl_q[LTEQ_RX_TERMINATION_SELECT_BIT];
			tx_internal_term_o <= host_s && term_ctrl_q[LTEQ_TX_TERMINATION_SELECT_BIT];
			term_impedance_apply_o <= host_s && term_ctrl_q[LTEQ_RX_TERMINATION_SELECT_BIT]
				&& term_ctrl_q[LTEQ_TX_TERMINATION_SELECT_BIT];
			term_impedance_code_o <= term_ctrl_q[LTEQ_IMP_LSB +: 2];
			term_impedance_ohms_o <= ohms_of(term_ctrl_q[LTEQ_IMP_LSB +: 2]);
			rx_fixed_resistor_select_o <= rx_fixed_resistor_select_q[LTEQ_RX_FIXED_RESISTOR_SELECT_LSB +: 2];
			rx_fixed_resistor_o <= host_s && term_ctrl_q[LTEQ_RX_TERMINATION_SELECT_BIT]
				&& (rx_fixed_resistor_select_q[LTEQ_RX_FIXED_RESISTOR_SELECT_LSB +: 2] != 2'h0);
		end
	end

	property p_eq_write;
		@(posedge clk_i) disable iff (!reset_n_i)
		commit && addr_q == LTEQ_OFS_EQ_CTRL |=> eq_select_o == $past(shift_next[4:0]);
	endproperty
	a_eq_write: assert property (p_eq_write) else $error("equalizer field not written");

	property p_rsvd_write;
		@(posedge clk_i) disable iff (!reset_n_i)
		commit && addr_q == LTEQ_OFS_EQ_CTRL |=> eq_ctrl_q[LTEQ_RSVD_LSB +: 3] == $past(shift_next[7:5]);
	endproperty
	a_rsvd_write: assert property (p_rsvd_write) else $error("spare bits not stored");

	property p_rx_term;
		@(posedge clk_i) disable iff (!reset_n_i)
		commit && addr_q == LTEQ_OFS_TERM_CTRL && host_s && $stable(host_s)
			##1 host_s |=> rx_internal_term_o == $past(term_ctrl_q[7]);
	endproperty
	a_rx_term: assert property (p_rx_term) else $error("rx termination mismatch");

	property p_tx_term;
		@(posedge clk_i) disable iff (!reset_n_i)
		!host_s |=> !tx_internal_term_o;
	endproperty
	a_tx_term: assert property (p_tx_term) else $error("tx internal outside host mode");

	property p_apply;
		@(posedge clk_i) disable iff (!reset_n_i)
		term_impedance_apply_o |-> rx_internal_term_o && tx_internal_term_o;
	endproperty
	a_apply: assert property (p_apply) else $error("impedance applied without internal termination");

	property p_ohms_75;
		@(posedge clk_i) disable iff (!reset_n_i)
		term_impedance_code_o == LTEQ_IMP_75 |-> term_impedance_ohms_o == LTEQ_OHMS_75;
	endproperty
	a_ohms_75: assert property (p_ohms_75) else $error("code 10 not 75 ohms");

	property p_ohms_100;
		@(posedge clk_i) disable iff (!reset_n_i)
		term_impedance_code_o == LTEQ_IMP_100 |-> term_impedance_ohms_o == LTEQ_OHMS_100;
	endproperty
	a_ohms_100: assert property (p_ohms_100) else $error("code 00 not 100 ohms");

	property p_fixed_res;
		@(posedge clk_i) disable iff (!reset_n_i)
		rx_fixed_resistor_o |-> rx_internal_term_o && rx_fixed_resistor_select_o != 2'h0;
	endproperty
	a_fixed_res: assert property (p_fixed_res) else $error("fixed resistor without internal rx");

	property p_sdo_oe;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(sp_sdo_oe_o) |-> sp_sdo_o == rdata_q[0];
	endproperty
	a_sdo_oe: assert property (p_sdo_oe) else $error("first read bit not on sdo");
endmodule
`default_nettype wire

// [lteq_pkg.sv]
package lteq_pkg;
	localparam logic [4:0] LTEQ_OFS_EQ_CTRL   = 5'h00;
	localparam logic [4:0] LTEQ_OFS_TERM_CTRL = 5'h01;
	localparam logic [4:0] LTEQ_OFS_RX_FIXED_RESISTOR_SELECT     = 5'h03;
	localparam logic [4:0] LTEQ_OFS_DEV_ID    = 5'h1e;
	localparam logic [4:0] LTEQ_OFS_REV_ID    = 5'h1f;

	localparam logic [7:0] LTEQ_RST_EQ_CTRL   = 8'h00;
	localparam logic [7:0] LTEQ_RST_TERM_CTRL = 8'h00;
	localparam logic [7:0] LTEQ_RST_RX_FIXED_RESISTOR_SELECT     = 8'h00;

	localparam int LTEQ_EQ_LSB      = 0;
	localparam int LTEQ_EQ_W        = 5;
	localparam int LTEQ_RSVD_LSB    = 5;
	localparam int LTEQ_RX_TERMINATION_SELECT_BIT  = 7;
	localparam int LTEQ_TX_TERMINATION_SELECT_BIT  = 6;
	localparam int LTEQ_IMP_LSB     = 4;
	localparam int LTEQ_RX_FIXED_RESISTOR_SELECT_LSB   = 3;

	localparam logic [1:0] LTEQ_IMP_100 = 2'h0;
	localparam logic [1:0] LTEQ_IMP_110 = 2'h1;
	localparam logic [1:0] LTEQ_IMP_75  = 2'h2;
	localparam logic [1:0] LTEQ_IMP_120 = 2'h3;
	localparam logic [7:0] LTEQ_OHMS_100 = 8'h64;
	localparam logic [7:0] LTEQ_OHMS_110 = 8'h6e;
	localparam logic [7:0] LTEQ_OHMS_75  = 8'h4b;
	localparam logic [7:0] LTEQ_OHMS_120 = 8'h78;

	// Frame: bit 0 read flag, bits 1..5 address, 6..7 spare, 8..15 data, all LSB first
	localparam logic [3:0] LTEQ_HDR_LAST  = 4'h7;
	localparam logic [3:0] LTEQ_DATA_LAST = 4'hf;

	// Identity values are arbitrary
	localparam logic [7:0] LTEQ_DEV_ID_DEF = 8'h5a;
	localparam logic [7:0] LTEQ_REV_ID_DEF = 8'h01;

	typedef enum logic [1:0] {LTEQ_IDLE, LTEQ_HDR, LTEQ_DATA, LTEQ_DONE} lteq_state_t;
endpackage

// [line_termination_equalizer_config_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module line_termination_equalizer_config_tb_top;
	import lteq_pkg::*;
	logic		clk_i, reset_n_i, host_mode_i, sp_cs_n_i, sp_sclk_i, sp_sdi_i;
	logic		sp_sdo_o, sp_sdo_oe_o, rx_o, tx_o, app_o, fix_o;
	logic [4:0]	eq_o;
	logic [1:0]	code_o, fsel_o;
	logic [7:0]	ohms_o, q;
	logic [7:0]	m [0:31];
	logic [7:0]	ohm_tab [0:3] = '{8'h64, 8'h6e, 8'h4b, 8'h78};
	logic [4:0]	ra [0:4] = '{5'h00, 5'h01, 5'h03, 5'h1e, 5'h1f};
	logic [4:0]	ua [0:4] = '{5'h02, 5'h05, 5'h10, 5'h1e, 5'h1f};
	int		n_errors, comparisons, cyc;

	lteq_config dut (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .host_mode_i(host_mode_i),
		.sp_cs_n_i(sp_cs_n_i), .sp_sclk_i(sp_sclk_i), .sp_sdi_i(sp_sdi_i),
		.sp_sdo_o(sp_sdo_o), .sp_sdo_oe_o(sp_sdo_oe_o), .eq_select_o(eq_o),
		.rx_internal_term_o(rx_o), .tx_internal_term_o(tx_o),
		.term_impedance_apply_o(app_o), .term_impedance_code_o(code_o),
		.term_impedance_ohms_o(ohms_o), .rx_fixed_resistor_o(fix_o),
		.rx_fixed_resistor_select_o(fsel_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task automatic conclude;
		$display("compares %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Hang guard, well above the expected run of about 20000 cycles
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [7:0] ev(input logic [4:0] a);
		ev = (a == 5'h1e) ? LTEQ_DEV_ID_DEF : (a == 5'h1f) ? LTEQ_REV_ID_DEF : m[a];
	endfunction

	// Half periods of six clocks leave margin over the four-clock minimum
	task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d, input int nb);
		logic [15:0] f;
		f = {d, 2'h0, a, rd};
		q = 8'h00;
		sp_cs_n_i <= 1'b0;
		for (int i = 0; i < nb; i++) begin
			sp_sdi_i <= f[i];
			repeat (5) @(posedge clk_i);
			@(negedge clk_i);
			if (rd && i >= 8) begin
				q[i-8] = sp_sdo_o;
				chk({7'h0, sp_sdo_oe_o}, 8'h01);
			end
			@(posedge clk_i);
			sp_sclk_i <= 1'b1;
			repeat (6) @(posedge clk_i);
			sp_sclk_i <= 1'b0;
		end
		repeat (6) @(posedge clk_i);
		sp_cs_n_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk({7'h0, sp_sdo_oe_o}, 8'h00);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		xfer(1'b0, a, d, 16);
		if (a == 5'h00 || a == 5'h01 || a == 5'h03) begin
			m[a] = d;
		end
	endtask

	task automatic outs;
		logic h;
		h = host_mode_i;
		chk({3'h0, eq_o}, {3'h0, m[0][4:0]});
		chk({7'h0, rx_o}, {7'h0, h & m[1][7]});
		chk({7'h0, tx_o}, {7'h0, h & m[1][6]});
		chk({6'h0, code_o}, {6'h0, m[1][5:4]});
		chk(ohms_o, ohm_tab[m[1][5:4]]);
		chk({7'h0, app_o}, {7'h0, h & m[1][7] & m[1][6]});
		chk({7'h0, fix_o}, {7'h0, h & m[1][7] & (m[3][4:3] != 2'h0)});
		chk({6'h0, fsel_o}, {6'h0, m[3][4:3]});
	endtask

	task automatic rd_all;
		for (int j = 0; j < 5; j++) begin
			xfer(1'b1, ra[j], 8'h00, 16);
			chk(q, ev(ra[j]));
		end
	endtask

	initial begin
		host_mode_i = 1'b0;
		sp_cs_n_i = 1'b1;
		sp_sclk_i = 1'b0;
		sp_sdi_i = 1'b0;
		reset_n_i = 1'b0;
		foreach (m[i]) m[i] = 8'h00;
		void'($urandom(32'hec3aeffc));
		repeat (16) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		outs();
		rd_all();
		$display("test reset values done");
		for (int k = 0; k < 6; k++) begin
			wr(5'h00, 8'($urandom));
			wr(5'h01, 8'($urandom));
			wr(5'h03, 8'($urandom));
			host_mode_i <= 1'($urandom);
			repeat (6) @(posedge clk_i);
			outs();
			rd_all();
		end
		$display("test random registers done");
		for (int c = 0; c < 32; c++) begin
			host_mode_i <= 1'(c >> 4);
			wr(5'h01, 8'(c << 4));
			repeat (6) @(posedge clk_i);
			outs();
		end
		$display("test termination codes done");
		for (int j = 0; j < 5; j++) begin
			wr(ua[j], 8'($urandom));
			xfer(1'b1, ua[j], 8'h00, 16);
			chk(q, ev(ua[j]));
		end
		$display("test unmapped access done");
		xfer(1'b0, 5'h00, ~m[0], 12);
		xfer(1'b1, 5'h00, 8'h00, 16);
		chk(q, m[0]);
		outs();
		$display("test aborted frame done");
		conclude();
	end
endmodule
`default_nettype wire
